// File: logic/fscr_core.sv
/*
 Fault cause, live status, reserved and command byte bank of the buck converter.
 Assumes the serial interface engine presents decoded byte accesses on core_clk
 and that protection and mode condition inputs are asynchronous levels.
*/
// Behaviour
// - Cause bytes set a bit on its event; zero means no event since clear.
// - Reading a cause byte clears its bits.
// - A read spares a cause bit whose condition is still present.
// - Cause A bit 7 sets on every change between current and voltage regulation.
// - Cause A bit 5 sets when the sync clock is out of range.
// - Cause A bit 4 sets when the frequency resistor is out of range.
// - Cause A bits 3 and 2 set on hard and soft thermal limits.
// - Cause A bit 0 sets on input over-voltage; bits 6 and 1 read zero.
// - Cause B bit 6 sets on main over-current; bit 7 reads zero.
// - Cause B bit 5 sets on output over-voltage.
// - Cause B bit 4 sets on output under-voltage in either mode.
// - Cause B bit 3 sets on auxiliary regulator under-voltage.
// - Cause B bits 2, 1, 0 set on bias over-current, over-voltage, under-voltage.
// - Status bits 7 and 6 show sync clock too fast and too slow.
// - Status bit 5 shows bias converter at full duty.
// - Status bit 4 shows current regulation, zero for voltage regulation.
// - Status bit 3 shows main converter at full duty.
// - Status bit 2 shows main power good; bits 1 and 0 read zero.
// - The reserved byte holds nothing and reads zero.
// - Writing one to command bit 1 applies the voltage code; reads zero.
// - Command bit 0 enables the main converter; command resets to zero.
// - A set mask bit suppresses the interrupt but the cause still records.
// - Mask-all forces every mask to one.
`timescale 1ns/1ps
`default_nettype none
`include "fscr_regs.svh"

module fscr_core (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire fscr_pkg::fscr_byte_t reg_wdata,
    output fscr_pkg::fscr_byte_t reg_rdata_r,
    input wire fscr_pkg::fscr_cond_s cond_async,
    input wire fscr_pkg::fscr_byte_t mask_a,
    input wire fscr_pkg::fscr_byte_t mask_b,
    input wire logic mask_all,
    output logic main_enable_r,
    output logic apply_voltage_code_r,
    output logic irq_r
);

    fscr_pkg::fscr_cond_s cond_meta_r;
    fscr_pkg::fscr_cond_s cond_r;
    logic cc_prev_r;
    logic cc_edge;
    fscr_pkg::fscr_byte_t hold_a;
    fscr_pkg::fscr_byte_t hold_b;
    fscr_pkg::fscr_byte_t set_a;
    fscr_pkg::fscr_byte_t status_v;
    fscr_pkg::fscr_byte_t cause_a;
    fscr_pkg::fscr_byte_t cause_b;
    fscr_pkg::fscr_byte_t eff_mask_a;
    fscr_pkg::fscr_byte_t eff_mask_b;
    fscr_pkg::fscr_byte_t reg_rdata_nxt;
    logic main_enable_nxt;
    logic apply_voltage_code_nxt;
    logic irq_nxt;
    logic rd_a;
    logic rd_b;
    logic wr_cmd;

    // Condition levels are synchronised before any logic reads them.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_meta_r <= '0;
            cond_r <= '0;
            cc_prev_r <= 1'b0;
        end else begin
            cond_meta_r <= cond_async;
            cond_r <= cond_meta_r;
            cc_prev_r <= cond_r.cc_mode;
        end
    end

    assign rd_a = reg_rd && (reg_addr == `FSCR_OFS_CAUSE_A);
    assign rd_b = reg_rd && (reg_addr == `FSCR_OFS_CAUSE_B);
    assign wr_cmd = reg_wr && (reg_addr == `FSCR_OFS_CMD);
    assign cc_edge = cond_r.cc_mode ^ cc_prev_r;

    always_comb begin
        hold_a = '0;
        hold_a[`FSCR_A_CCCV] = cc_edge;
        hold_a[`FSCR_A_SYNC] = cond_r.sync_out_of_range;
        hold_a[`FSCR_A_FREQUENCY_SET_RESISTOR] = cond_r.frequency_set_resistor_bad;
        hold_a[`FSCR_A_THARD] = cond_r.hard_thermal_limit;
        hold_a[`FSCR_A_TSOFT] = cond_r.soft_thermal_limit;
        hold_a[`FSCR_A_OVLO] = cond_r.input_overvoltage_lockout;
        set_a = hold_a;
        hold_b = '0;
        hold_b[`FSCR_B_MOCP] = cond_r.main_overcurrent;
        hold_b[`FSCR_B_OOVP] = cond_r.output_overvoltage_limit;
        hold_b[`FSCR_B_OUVP] = cond_r.output_undervoltage;
        hold_b[`FSCR_B_AUXUV] = cond_r.auxiliary_linear_regulator_uv;
        hold_b[`FSCR_B_BOCP] = cond_r.bias_rail_overcurrent;
        hold_b[`FSCR_B_BOVP] = cond_r.bias_rail_overvoltage;
        hold_b[`FSCR_B_BUV] = cond_r.bias_rail_undervoltage;
        status_v = '0;
        status_v[`FSCR_S_FAST] = cond_r.sync_clock_too_fast;
        status_v[`FSCR_S_SLOW] = cond_r.sync_clock_too_slow;
        status_v[`FSCR_S_BFULL] = cond_r.bias_full_duty;
        status_v[`FSCR_S_CC] = cond_r.cc_mode;
        status_v[`FSCR_S_MFULL] = cond_r.main_full_duty;
        status_v[`FSCR_S_PG] = cond_r.main_power_good;
    end

    // Unused cause bits are forced to zero by the used masks.
    fscr_cause_byte #(
        .USED(`FSCR_CAUSE_A_USED)
    ) u_cause_a (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set_vec(set_a),
        .hold_vec(hold_a),
        .rd_clr(rd_a),
        .cause_r(cause_a)
    );

    fscr_cause_byte #(
        .USED(`FSCR_CAUSE_B_USED)
    ) u_cause_b (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set_vec(hold_b),
        .hold_vec(hold_b),
        .rd_clr(rd_b),
        .cause_r(cause_b)
    );

    // Read data returns the value before any clear takes effect.
    always_comb begin
        eff_mask_a = mask_a | {8{mask_all}};
        eff_mask_b = mask_b | {8{mask_all}};
        irq_nxt = |(cause_a & ~eff_mask_a) || |(cause_b & ~eff_mask_b);
        reg_rdata_nxt = reg_rdata_r;
        if (reg_rd) begin
            unique case (reg_addr)
                `FSCR_OFS_CAUSE_A: reg_rdata_nxt = cause_a;
                `FSCR_OFS_CAUSE_B: reg_rdata_nxt = cause_b;
                `FSCR_OFS_STATUS: reg_rdata_nxt = status_v;
                `FSCR_OFS_RSVD: reg_rdata_nxt = 8'h00;
                `FSCR_OFS_CMD: reg_rdata_nxt = {7'h00, main_enable_r};
                default: reg_rdata_nxt = 8'h00;
            endcase
        end
        main_enable_nxt = main_enable_r;
        apply_voltage_code_nxt = 1'b0;
        if (wr_cmd) begin
            main_enable_nxt = reg_wdata[`FSCR_CMD_ENABLE];
            apply_voltage_code_nxt = reg_wdata[`FSCR_CMD_APPLY];
        end
    end

    // Only the command byte is writable; other offsets ignore writes.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= `FSCR_RDATA_RESET;
            main_enable_r <= 1'(`FSCR_CMD_RESET >> `FSCR_CMD_ENABLE);
            apply_voltage_code_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            reg_rdata_r <= reg_rdata_nxt;
            main_enable_r <= main_enable_nxt;
            apply_voltage_code_r <= apply_voltage_code_nxt;
            irq_r <= irq_nxt;
        end
    end

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    a_unused_cause_zero: assert property (
        cause_a[6] == 1'b0 && cause_a[1] == 1'b0 && cause_b[7] == 1'b0)
        else $error("Unused cause bit is set.");

    a_read_clears_a: assert property (
        (rd_a && hold_a == 8'h00) |=> cause_a == 8'h00)
        else $error("Cause A not cleared by read.");

    a_read_keeps_held: assert property (
        (rd_b && cond_r.output_overvoltage_limit) |=> cause_b[`FSCR_B_OOVP])
        else $error("Held cause bit cleared by read.");

    a_cccv_edge_set: assert property (
        (cond_r.cc_mode != cc_prev_r) |=> cause_a[`FSCR_A_CCCV])
        else $error("Regulation change not recorded.");

    a_thermal_set: assert property (
        cond_r.hard_thermal_limit |=> cause_a[`FSCR_A_THARD]
        ##1 (cause_a[`FSCR_A_THARD] || $past(rd_a)))
        else $error("Hard thermal event not recorded.");

    a_bias_uv_set: assert property (
        cond_r.bias_rail_undervoltage |=> cause_b[`FSCR_B_BUV])
        else $error("Bias under-voltage not recorded.");

    a_status_read: assert property (
        (reg_rd && reg_addr == `FSCR_OFS_STATUS) |=> reg_rdata_r == $past(status_v))
        else $error("Status read data wrong.");

    a_rsvd_zero: assert property (
        (reg_rd && reg_addr == `FSCR_OFS_RSVD) |=> reg_rdata_r == 8'h00)
        else $error("Reserved byte not zero.");

    a_apply_pulse: assert property (
        (wr_cmd && reg_wdata[`FSCR_CMD_APPLY]) |=> apply_voltage_code_r
        ##1 (!apply_voltage_code_r || $past(wr_cmd)))
        else $error("Apply pulse wrong.");

    a_enable_write: assert property (
        wr_cmd |=> main_enable_r == $past(reg_wdata[`FSCR_CMD_ENABLE]))
        else $error("Enable bit not written.");

    a_mask_all_quiet: assert property (
        mask_all |=> !irq_r)
        else $error("Interrupt raised under mask-all.");

    a_irq_unmasked: assert property (
        (!mask_all && mask_b == 8'h00 && cause_b != 8'h00) |=> irq_r)
        else $error("Unmasked cause did not raise interrupt.");

    a_ro_write_ignored: assert property (
        (reg_wr && !reg_rd && reg_addr == `FSCR_OFS_CAUSE_A && hold_a == 8'h00)
        |=> cause_a == $past(cause_a))
        else $error("Write changed a cause byte.");

    a_sync_range_set: assert property (
        cond_r.sync_out_of_range |=> cause_a[`FSCR_A_SYNC])
        else $error("Sync range event not recorded.");

    a_frequency_set_resistor_range_set: assert property (
        cond_r.frequency_set_resistor_bad |=> cause_a[`FSCR_A_FREQUENCY_SET_RESISTOR])
        else $error("Frequency resistor event not recorded.");

    a_soft_thermal_set: assert property (
        cond_r.soft_thermal_limit |=> cause_a[`FSCR_A_TSOFT])
        else $error("Soft thermal event not recorded.");

    a_ovlo_set: assert property (
        cond_r.input_overvoltage_lockout |=> cause_a[`FSCR_A_OVLO])
        else $error("Input over-voltage not recorded.");

    a_main_ocp_set: assert property (
        cond_r.main_overcurrent |=> cause_b[`FSCR_B_MOCP])
        else $error("Main over-current not recorded.");

    a_out_ovp_set: assert property (
        cond_r.output_overvoltage_limit |=> cause_b[`FSCR_B_OOVP])
        else $error("Output over-voltage not recorded.");

    a_out_uvp_set: assert property (
        cond_r.output_undervoltage |=> cause_b[`FSCR_B_OUVP])
        else $error("Output under-voltage not recorded.");

    a_aux_uv_set: assert property (
        cond_r.auxiliary_linear_regulator_uv |=> cause_b[`FSCR_B_AUXUV])
        else $error("Auxiliary regulator under-voltage not recorded.");

    a_bias_ocp_set: assert property (
        cond_r.bias_rail_overcurrent |=> cause_b[`FSCR_B_BOCP])
        else $error("Bias over-current not recorded.");

    a_bias_ovp_set: assert property (
        cond_r.bias_rail_overvoltage |=> cause_b[`FSCR_B_BOVP])
        else $error("Bias over-voltage not recorded.");

    a_read_clears_b: assert property (
        (rd_b && hold_b == 8'h00) |=> cause_b == 8'h00)
        else $error("Cause B not cleared by read.");

    a_status_cc_bit: assert property (
        (reg_rd && reg_addr == `FSCR_OFS_STATUS)
        |=> reg_rdata_r[`FSCR_S_CC] == $past(cond_r.cc_mode))
        else $error("Regulation mode status wrong.");

    a_status_duty_bits: assert property (
        (reg_rd && reg_addr == `FSCR_OFS_STATUS)
        |=> reg_rdata_r[`FSCR_S_BFULL] == $past(cond_r.bias_full_duty)
        && reg_rdata_r[`FSCR_S_MFULL] == $past(cond_r.main_full_duty))
        else $error("Full duty status wrong.");

    a_cmd_readback: assert property (
        (reg_rd && reg_addr == `FSCR_OFS_CMD) |=> reg_rdata_r == {7'h00, $past(main_enable_r)})
        else $error("Command read data wrong.");

    a_irq_release: assert property (
        (cause_a == 8'h00 && cause_b == 8'h00) |=> !irq_r)
        else $error("Interrupt held with no cause.");

    a_irq_cause_a: assert property (
        (!mask_all && mask_a == 8'h00 && cause_a != 8'h00) |=> irq_r)
        else $error("Unmasked cause A did not raise interrupt.");

    a_mask_keeps_cause: assert property (
        (mask_all && cond_r.hard_thermal_limit) |=> cause_a[`FSCR_A_THARD])
        else $error("Masked event not recorded.");

    a_apply_idle: assert property (
        !wr_cmd |=> !apply_voltage_code_r)
        else $error("Apply pulse without command write.");

    a_enable_hold: assert property (
        !wr_cmd |=> $stable(main_enable_r))
        else $error("Enable changed without command write.");

    c_read_clear: cover property (cause_a != 8'h00 ##1 rd_a ##1 cause_a == 8'h00);
    c_enable_on: cover property (wr_cmd && reg_wdata[`FSCR_CMD_ENABLE] ##1 main_enable_r);
    c_irq_raise: cover property (!irq_r ##1 irq_r);
    c_held_read: cover property (rd_b && hold_b != 8'h00);

endmodule
`default_nettype wire

// File: logic/fscr_regs.svh
/*
 Register offsets, field positions, used-bit masks and reset values of the
 fault, status and command byte bank. Assumes byte-wide register addresses.
*/
`ifndef FSCR_REGS_SVH
`define FSCR_REGS_SVH

`define FSCR_OFS_CAUSE_A 8'h01
`define FSCR_OFS_CAUSE_B 8'h02
`define FSCR_OFS_STATUS 8'h03
`define FSCR_OFS_RSVD 8'h04
`define FSCR_OFS_CMD 8'h05

`define FSCR_CAUSE_A_USED 8'hBD
`define FSCR_CAUSE_B_USED 8'h7F
`define FSCR_CAUSE_RESET 8'h00
`define FSCR_CMD_RESET 8'h00
`define FSCR_RDATA_RESET 8'h00

`define FSCR_A_CCCV 7
`define FSCR_A_SYNC 5
`define FSCR_A_FREQUENCY_SET_RESISTOR 4
`define FSCR_A_THARD 3
`define FSCR_A_TSOFT 2
`define FSCR_A_OVLO 0

`define FSCR_B_MOCP 6
`define FSCR_B_OOVP 5
`define FSCR_B_OUVP 4
`define FSCR_B_AUXUV 3
`define FSCR_B_BOCP 2
`define FSCR_B_BOVP 1
`define FSCR_B_BUV 0

`define FSCR_S_FAST 7
`define FSCR_S_SLOW 6
`define FSCR_S_BFULL 5
`define FSCR_S_CC 4
`define FSCR_S_MFULL 3
`define FSCR_S_PG 2

`define FSCR_CMD_APPLY 1
`define FSCR_CMD_ENABLE 0

`endif

// File: logic/fscr_pkg.sv
/*
 Types shared by the fault, status and command byte bank.
 Assumes the constants header is included by the design files.
*/
`default_nettype none

package fscr_pkg;

    typedef logic [7:0] fscr_byte_t;

    typedef struct packed {
        logic cc_mode;
        logic sync_out_of_range;
        logic frequency_set_resistor_bad;
        logic hard_thermal_limit;
        logic soft_thermal_limit;
        logic input_overvoltage_lockout;
        logic main_overcurrent;
        logic output_overvoltage_limit;
        logic output_undervoltage;
        logic auxiliary_linear_regulator_uv;
        logic bias_rail_overcurrent;
        logic bias_rail_overvoltage;
        logic bias_rail_undervoltage;
        logic sync_clock_too_fast;
        logic sync_clock_too_slow;
        logic bias_full_duty;
        logic main_full_duty;
        logic main_power_good;
    } fscr_cond_s;

endpackage

`default_nettype wire

// File: logic/fscr_cause_byte.sv
/*
 One sticky interrupt-cause byte with clear on read.
 Assumes set and hold vectors and the read strobe come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fscr_regs.svh"

module fscr_cause_byte #(
    parameter logic [7:0] USED = 8'hFF
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire fscr_pkg::fscr_byte_t set_vec,
    input wire fscr_pkg::fscr_byte_t hold_vec,
    input wire logic rd_clr,
    output fscr_pkg::fscr_byte_t cause_r
);

    fscr_pkg::fscr_byte_t cause_nxt;

    // A set wins over the clear, and a clear spares bits whose cause persists.
    always_comb begin
        cause_nxt = USED & (set_vec | (cause_r & ~({8{rd_clr}} & ~hold_vec)));
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cause_r <= `FSCR_CAUSE_RESET;
        end else begin
            cause_r <= cause_nxt;
        end
    end

endmodule
`default_nettype wire

// File: tb/fscr_host_model.sv
/*
 Host side of the decoded register port: single-byte reads and writes.
 Assumes the bank samples requests on the rising edge of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module fscr_host_model (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output fscr_pkg::fscr_byte_t reg_wdata,
    input wire fscr_pkg::fscr_byte_t reg_rdata_r
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // Released lines show the inverse of their last value.
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_r;
    endtask
endmodule

`default_nettype wire

// File: tb/tb_fscr_core.sv
/*
 Self-checking bench of the fault, status and command byte bank.
 Assumes the host model drives the register port on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_fscr_core;
    logic core_clk;
    logic arst_n;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    fscr_pkg::fscr_byte_t reg_wdata;
    fscr_pkg::fscr_byte_t reg_rdata_r;
    fscr_pkg::fscr_cond_s cond;
    fscr_pkg::fscr_byte_t mask_a;
    fscr_pkg::fscr_byte_t mask_b;
    logic mask_all;
    logic main_enable_r;
    logic apply_voltage_code_r;
    logic irq_r;
    int err_count;
    int samples_checked;
    logic [31:0] seed;
    fscr_pkg::fscr_byte_t ea;
    fscr_pkg::fscr_byte_t eb;
    logic prev_cc;
    logic tog;

    fscr_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));

    fscr_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .cond_async(cond), .mask_a(mask_a), .mask_b(mask_b), .mask_all(mask_all),
        .main_enable_r(main_enable_r), .apply_voltage_code_r(apply_voltage_code_r),
        .irq_r(irq_r));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic fscr_pkg::fscr_byte_t f_a(input fscr_pkg::fscr_cond_s c);
        return {2'b00, c.sync_out_of_range, c.frequency_set_resistor_bad,
            c.hard_thermal_limit, c.soft_thermal_limit, 1'b0, c.input_overvoltage_lockout};
    endfunction

    function automatic fscr_pkg::fscr_byte_t f_b(input fscr_pkg::fscr_cond_s c);
        return {1'b0, c.main_overcurrent, c.output_overvoltage_limit, c.output_undervoltage,
            c.auxiliary_linear_regulator_uv, c.bias_rail_overcurrent,
            c.bias_rail_overvoltage, c.bias_rail_undervoltage};
    endfunction

    function automatic fscr_pkg::fscr_byte_t f_s(input fscr_pkg::fscr_cond_s c);
        return {c.sync_clock_too_fast, c.sync_clock_too_slow, c.bias_full_duty, c.cc_mode,
            c.main_full_duty, c.main_power_good, 2'b00};
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd_byte(a, d);
        check(nm, d, exp);
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        arst_n = 1'b0;
        cond = '0;
        mask_a = 8'h00;
        mask_b = 8'h00;
        mask_all = 1'b0;
        err_count = 0;
        samples_checked = 0;
        seed = 32'h1682E898;
        prev_cc = 1'b0;
        repeat (16) @(negedge core_clk);
        arst_n = 1'b1;
        check("enable", {7'h00, main_enable_r}, 8'h00);
        rchk("cmd", 8'h05, 8'h00);
        rchk("rsvd", 8'h04, 8'h00);
        rchk("unmapped", 8'hC3, 8'h00);
        host_u.wr_byte(8'h05, 8'h03);
        check("apply", {7'h00, apply_voltage_code_r}, 8'h01);
        check("enable", {7'h00, main_enable_r}, 8'h01);
        @(negedge core_clk);
        check("apply", {7'h00, apply_voltage_code_r}, 8'h00);
        rchk("cmd", 8'h05, 8'h01);
        host_u.wr_byte(8'h05, 8'h02);
        check("apply", {7'h00, apply_voltage_code_r}, 8'h01);
        check("enable", {7'h00, main_enable_r}, 8'h00);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            cond = (i == 0) ? '1 : fscr_pkg::fscr_cond_s'(seed[17:0]);
            mask_a = (i == 0) ? 8'h00 : seed[25:18];
            seed = xs(seed);
            mask_b = (i == 0) ? 8'h00 : seed[7:0];
            mask_all = (i == 0) ? 1'b0 : seed[8];
            tog = cond.cc_mode ^ prev_cc;
            prev_cc = cond.cc_mode;
            ea = f_a(cond);
            eb = f_b(cond);
            repeat (5) @(negedge core_clk);
            check("irq", {7'h00, irq_r}, {7'h00,
                (|(({tog, 7'h00} | ea) & ~(mask_a | {8{mask_all}})))
                || (|(eb & ~(mask_b | {8{mask_all}})))});
            for (int a = 1; a < 5; a++) host_u.wr_byte(8'(a), seed[31:24]);
            rchk("status", 8'h03, f_s(cond));
            rchk("cause_a", 8'h01, ea | {tog, 7'h00});
            rchk("cause_b", 8'h02, eb);
            rchk("cause_a held", 8'h01, ea);
            rchk("cause_b held", 8'h02, eb);
            cond = '0;
            cond.cc_mode = prev_cc;
            repeat (4) @(negedge core_clk);
            rchk("cause_a kept", 8'h01, ea);
            rchk("cause_b kept", 8'h02, eb);
            rchk("cause_a clr", 8'h01, 8'h00);
            rchk("cause_b clr", 8'h02, 8'h00);
            @(negedge core_clk);
            check("irq clr", {7'h00, irq_r}, 8'h00);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
